// *** scn_pkg.sv ***
package scn_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_SRC = 5'h00;
  localparam logic [4:0] ADDR_CTL = 5'h04;
  localparam logic [4:0] ADDR_OSC = 5'h08;
  localparam logic [4:0] ADDR_CNT = 5'h0c;
  localparam logic [4:0] ADDR_FLG = 5'h10;
  // source_and_flag_select fields
  localparam int SRC_S2_LSB = 14;
  localparam int SRC_S1_LSB = 12;
  localparam int SRC_BMODE_LSB = 10;
  localparam int SRC_AMODE_LSB = 8;
  localparam int SRC_PATH_BIT = 7;
  localparam int SRC_OCOND_LSB = 4;
  localparam logic [15:0] SRC_WMASK = 16'hfff0;
  // counter_and_divider_control fields
  localparam int CTL_CLR_BIT = 15;
  localparam int CTL_BEN_BIT = 14;
  localparam int CTL_ADN_BIT = 13;
  localparam int CTL_AUP_BIT = 12;
  localparam int CTL_Q7_BIT = 11;
  localparam int CTL_Q6_BIT = 10;
  localparam int CTL_DIVB_LSB = 7;
  localparam int CTL_DIVA_LSB = 4;
  localparam int CTL_ACLK_LSB = 2;
  localparam int CTL_SUB_MAIN_CLOCK_LSB = 0;
  // oscillator_and_repeat_control fields
  localparam int OSC_CAL_LSB = 8;
  localparam int OSC_RPT_BIT = 7;
  localparam int OSC_TRIM_LSB = 3;
  localparam int OSC_NOM_BIT = 2;
  localparam int OSC_GO_BIT = 1;
  localparam int OSC_EN_BIT = 0;
  // Flag register bits, write one to clear
  localparam int FLG_OUT_BIT = 0;
  localparam int FLG_A_BIT = 1;
  localparam int FLG_B_BIT = 2;
  // Reset values
  localparam logic [15:0] SRC_RST = 16'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [7:0] OSC_RST = 8'h40;
  // Calibration window in aux clock periods
  localparam logic [2:0] CAL_SHORT = 3'h1;
  localparam logic [2:0] CAL_LONG = 3'h4;
  // Counter flag modes
  localparam logic [1:0] FM_EACH = 2'h0;
  localparam logic [1:0] FM_MOD4 = 2'h1;
  localparam logic [1:0] FM_MOD64 = 2'h2;
  localparam logic [1:0] FM_WRAP = 2'h3;

  typedef struct packed {
    logic s2;
    logic s1;
  } scn_src_t;

  typedef struct packed {
    logic entry_bit_7;
    logic entry_bit_6;
  } scn_next_t;

  typedef enum {CAL_IDLE, CAL_ARM, CAL_RUN} scn_cal_t;
endpackage

// *** scn_if.sv ***
`timescale 1ns/1ps
module scn_if
  import scn_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [3:0] afe_out,
  input wire logic aclk,
  input wire logic sub_main_clock,
  input wire logic osc_clk,
  input wire logic tsm_excite,
  input wire logic comp_out,
  input wire logic seq_end,
  input wire logic entry_strobe,
  input wire logic [7:0] entry_bits,
  output scn_src_t psm_src,
  output scn_next_t next_use,
  output logic seq_start,
  output logic aclk_tick,
  output logic sub_main_clock_tick,
  output logic hf_clk_sel,
  output logic [3:0] osc_trim,
  output logic osc_nominal_sel,
  output logic out_cond_flag,
  output logic cnt_a_flag,
  output logic cnt_b_flag
);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic div_hit(input logic [2:0] cnt, input logic [1:0] code);
    logic [2:0] mask;
    mask = 3'((4'h1 << code) - 4'h1);
    div_hit = (cnt & mask) == mask;
  endfunction

  function automatic logic flag_hit(input logic [1:0] mode, input logic [7:0] val, input logic wrap);
    flag_hit = 1'b0;
    unique case (mode)
      FM_EACH: flag_hit = 1'b1;
      FM_MOD4: flag_hit = val[1:0] == 2'h0;
      FM_MOD64: flag_hit = val[5:0] == 6'h00;
      FM_WRAP: flag_hit = wrap;
    endcase
  endfunction

  // Two-flop synchronisers: afe[3:0], aclk, sub_main_clock, osc, excite, comp
  logic [8:0] sync1_r, sync2_r;
  logic [2:0] clk_prev_r;
  logic [15:0] src_r, ctl_r;
  logic [7:0] osc_r, cal_cnt_r, cnt_a_r, cnt_b_r;
  logic [2:0] flg_r, aclk_cnt_r, sub_main_clock_cnt_r, cal_per_r;
  logic [8:0] trig_cnt_r;
  logic cond_prev_r, wait_r;
  scn_cal_t cal_r;

  wire [3:0] afe_s = sync2_r[3:0];
  wire aclk_rise = sync2_r[4] & ~clk_prev_r[0];
  wire sub_main_clock_rise = sync2_r[5] & ~clk_prev_r[1];
  wire osc_rise = sync2_r[6] & ~clk_prev_r[2];
  wire req = read | write;
  wire ack = req & ~wait_r;
  wire wr_ack = write & ~wait_r;
  wire rd_clr = read & ~wait_r & (address == ADDR_CNT) & ctl_r[CTL_CLR_BIT];

  // Processing state machine sources
  wire [1:0] s2_sel = src_r[SRC_S2_LSB +: 2];
  wire [1:0] s1_sel = src_r[SRC_S1_LSB +: 2];
  wire path_sel = src_r[SRC_PATH_BIT];
  wire s2_nxt = path_sel ? afe_s[s2_sel] : sync2_r[8];
  wire s1_nxt = path_sel ? afe_s[s1_sel] : sync2_r[7];
  wire q6_en = ctl_r[CTL_Q6_BIT];
  wire b7_nxt = entry_bits[7] & ctl_r[CTL_Q7_BIT] & q6_en;
  wire b6_nxt = entry_bits[6] & q6_en;

  // Counters
  wire a_up = entry_strobe & entry_bits[1] & ctl_r[CTL_AUP_BIT];
  wire a_dn = entry_strobe & entry_bits[2] & ctl_r[CTL_ADN_BIT];
  wire a_cnt = a_up ^ a_dn;
  wire [7:0] a_new = a_up ? cnt_a_r + 8'h01 : cnt_a_r - 8'h01;
  wire b_cnt = entry_strobe & entry_bits[2] & ctl_r[CTL_BEN_BIT];
  wire [7:0] b_new = cnt_b_r - 8'h01;
  wire a_wrap = a_up & (cnt_a_r == 8'hff);
  wire b_wrap = cnt_b_r == 8'h01;
  wire a_evt = a_cnt & flag_hit(src_r[SRC_AMODE_LSB +: 2], a_new, a_wrap);
  wire b_evt = b_cnt & flag_hit(src_r[SRC_BMODE_LSB +: 2], b_new, b_wrap);
  wire [7:0] cnt_a_nxt = rd_clr ? 8'h00 : a_cnt ? a_new : cnt_a_r;
  wire [7:0] cnt_b_nxt = rd_clr ? 8'h00 : b_cnt ? b_new : cnt_b_r;

  // Output condition flag, rising edge of the selected condition
  wire [2:0] ocond = src_r[SRC_OCOND_LSB +: 3];
  wire cond_now = afe_s[ocond[2:1]] ^ ocond[0];
  wire o_evt = cond_now & ~cond_prev_r;

  // Sticky flags, set wins over write-one-to-clear
  wire [2:0] flg_clr = (wr_ack && address == ADDR_FLG && byteenable[0]) ? writedata[2:0] : 3'h0;
  wire [2:0] flg_set = {b_evt, a_evt, o_evt};
  wire [2:0] flg_nxt = (flg_r & ~flg_clr) | flg_set;

  // Start trigger and clock dividers
  wire [3:0] odd_a = {ctl_r[CTL_DIVA_LSB +: 3], 1'b1};
  wire [3:0] odd_b = {ctl_r[CTL_DIVB_LSB +: 3], 1'b1};
  wire [8:0] trig_ratio = {8'(odd_a) * 8'(odd_b), 1'b0};
  wire trig_wrap = trig_cnt_r >= trig_ratio - 9'h001;
  wire [8:0] trig_nxt = aclk_rise ? (trig_wrap ? 9'h000 : trig_cnt_r + 9'h001) : trig_cnt_r;
  wire start_nxt = osc_r[OSC_RPT_BIT] ? seq_end : (aclk_rise & trig_wrap);
  wire aclk_tick_nxt = aclk_rise & div_hit(aclk_cnt_r, ctl_r[CTL_ACLK_LSB +: 2]);
  wire sub_main_clock_tick_nxt = sub_main_clock_rise & div_hit(sub_main_clock_cnt_r, ctl_r[CTL_SUB_MAIN_CLOCK_LSB +: 2]);

  // Oscillator calibration
  wire osc_en = osc_r[OSC_EN_BIT];
  wire [2:0] cal_target = osc_r[OSC_NOM_BIT] ? CAL_LONG : CAL_SHORT;
  wire cal_go = osc_r[OSC_GO_BIT] & osc_en;
  wire cal_done = (cal_r == CAL_RUN) & aclk_rise & (cal_per_r + 3'h1 == cal_target);
  wire [15:0] osc_merged = merge({8'h00, osc_r}, writedata, byteenable);
  wire [7:0] osc_wr = osc_merged[7:0];
  wire [7:0] osc_nxt = (wr_ack && address == ADDR_OSC) ? osc_wr : (cal_done ? osc_r & 8'hfd : osc_r);
  scn_cal_t cal_nxt;
  always_comb begin
    cal_nxt = cal_r;
    unique case (cal_r)
      CAL_IDLE: if (cal_go) cal_nxt = CAL_ARM;
      CAL_ARM: if (!osc_en) cal_nxt = CAL_IDLE; else if (aclk_rise) cal_nxt = CAL_RUN;
      CAL_RUN: if (!osc_en || cal_done) cal_nxt = CAL_IDLE;
    endcase
  end
  wire [7:0] cal_cnt_nxt = (cal_r == CAL_IDLE && cal_go) ? 8'h00 :
    (cal_r == CAL_RUN && osc_rise && cal_cnt_r != 8'hff) ? cal_cnt_r + 8'h01 : cal_cnt_r;
  wire [2:0] cal_per_nxt = (cal_r != CAL_RUN) ? 3'h0 : aclk_rise ? cal_per_r + 3'h1 : cal_per_r;

  // Register read decode and write merge
  wire [15:0] src_view = {src_r[15:4], afe_s};
  wire [15:0] osc_view = {cal_cnt_r, osc_r};
  wire [15:0] rd_word = (address == ADDR_SRC) ? src_view :
    (address == ADDR_CTL) ? ctl_r :
    (address == ADDR_OSC) ? osc_view :
    (address == ADDR_CNT) ? {cnt_b_r, cnt_a_r} :
    (address == ADDR_FLG) ? {13'h0, flg_r} : 16'h0000;
  wire [15:0] src_nxt = (wr_ack && address == ADDR_SRC) ? merge(src_r, writedata, byteenable) & SRC_WMASK : src_r;
  wire [15:0] ctl_nxt = (wr_ack && address == ADDR_CTL) ? merge(ctl_r, writedata, byteenable) : ctl_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      clk_prev_r <= 3'h0;
    end else begin
      sync1_r <= {comp_out, tsm_excite, osc_clk, sub_main_clock, aclk, afe_out};
      sync2_r <= sync1_r;
      clk_prev_r <= sync2_r[6:4];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wait_r <= 1'b1;
      readdata <= 32'h0000_0000;
      src_r <= SRC_RST;
      ctl_r <= CTL_RST;
      osc_r <= OSC_RST;
    end else begin
      wait_r <= ~(req & wait_r);
      readdata <= (read & wait_r) ? {16'h0000, rd_word} : readdata;
      src_r <= src_nxt;
      ctl_r <= ctl_nxt;
      osc_r <= osc_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_a_r <= 8'h00;
      cnt_b_r <= 8'h00;
      flg_r <= 3'h0;
      cond_prev_r <= 1'b0;
      cal_r <= CAL_IDLE;
      cal_cnt_r <= 8'h00;
      cal_per_r <= 3'h0;
    end else begin
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
      flg_r <= flg_nxt;
      cond_prev_r <= cond_now;
      cal_r <= cal_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      cal_per_r <= cal_per_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      trig_cnt_r <= 9'h000;
      aclk_cnt_r <= 3'h0;
      sub_main_clock_cnt_r <= 3'h0;
      seq_start <= 1'b0;
      aclk_tick <= 1'b0;
      sub_main_clock_tick <= 1'b0;
      psm_src <= '0;
      next_use <= '0;
    end else begin
      trig_cnt_r <= trig_nxt;
      aclk_cnt_r <= aclk_rise ? aclk_cnt_r + 3'h1 : aclk_cnt_r;
      sub_main_clock_cnt_r <= sub_main_clock_rise ? sub_main_clock_cnt_r + 3'h1 : sub_main_clock_cnt_r;
      seq_start <= start_nxt;
      aclk_tick <= aclk_tick_nxt;
      sub_main_clock_tick <= sub_main_clock_tick_nxt;
      psm_src <= '{s2: s2_nxt, s1: s1_nxt};
      next_use <= entry_strobe ? '{entry_bit_7: b7_nxt, entry_bit_6: b6_nxt} : next_use;
    end
  end

  // Flag and oscillator outputs mirror their registers
  always_ff @(posedge clock) begin
    if (reset) begin
      out_cond_flag <= 1'b0;
      cnt_a_flag <= 1'b0;
      cnt_b_flag <= 1'b0;
      hf_clk_sel <= 1'b0;
      osc_trim <= OSC_RST[OSC_TRIM_LSB +: 4];
      osc_nominal_sel <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      out_cond_flag <= flg_nxt[FLG_OUT_BIT];
      cnt_a_flag <= flg_nxt[FLG_A_BIT];
      cnt_b_flag <= flg_nxt[FLG_B_BIT];
      hf_clk_sel <= osc_nxt[OSC_EN_BIT];
      osc_trim <= osc_nxt[OSC_TRIM_LSB +: 4];
      osc_nominal_sel <= osc_nxt[OSC_NOM_BIT];
      waitrequest <= ~(req & wait_r);
    end
  end

  property p_src_s2;
    @(posedge clock) disable iff (reset) path_sel |=> psm_src.s2 == $past(afe_s[s2_sel]);
  endproperty
  a_src_s2: assert property (p_src_s2) else $error("second source mismatch");

  property p_src_path;
    @(posedge clock) disable iff (reset) !path_sel |=> psm_src.s1 == $past(sync2_r[7]);
  endproperty
  a_src_path: assert property (p_src_path) else $error("first source not excitation");

  property p_clr_read;
    @(posedge clock) disable iff (reset) rd_clr |=> cnt_a_r == 8'h00 && cnt_b_r == 8'h00;
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("counter not cleared by read");

  property p_b_hold;
    @(posedge clock) disable iff (reset) (!ctl_r[CTL_BEN_BIT] && !rd_clr) |=> $stable(cnt_b_r);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("counter B moved while disabled");

  property p_a_up;
    @(posedge clock) disable iff (reset) (a_up && !a_dn && !rd_clr) |=> cnt_a_r == $past(cnt_a_r) + 8'h01;
  endproperty
  a_a_up: assert property (p_a_up) else $error("counter A did not increment");

  property p_bit7;
    @(posedge clock) disable iff (reset) (entry_strobe && !q6_en) |=> !next_use.entry_bit_7 && !next_use.entry_bit_6;
  endproperty
  a_bit7: assert property (p_bit7) else $error("entry bits used without enable");

  property p_sticky;
    @(posedge clock) disable iff (reset) (flg_r[FLG_A_BIT] && !flg_clr[FLG_A_BIT]) |=> flg_r[FLG_A_BIT] && cnt_a_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_trig;
    @(posedge clock) disable iff (reset) (aclk_rise && trig_wrap) |=> trig_cnt_r == 9'h000;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger count did not restart");

  property p_cal_off;
    @(posedge clock) disable iff (reset) (!osc_en && cal_r == CAL_IDLE) |=> cal_r == CAL_IDLE;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("calibration without oscillator");

  property p_hf_sel;
    @(posedge clock) disable iff (reset) (wr_ack && address == ADDR_OSC && byteenable[0]) |=>
      hf_clk_sel == $past(writedata[OSC_EN_BIT]);
  endproperty
  a_hf_sel: assert property (p_hf_sel) else $error("clock select mismatch");

endmodule

// *** scn_afe_model.sv ***
`timescale 1ns/1ps
module scn_afe_model (
  input wire logic clock,
  input wire logic [3:0] afe_set,
  input wire logic [1:0] ec_set,
  input wire logic seq_start,
  output logic [3:0] afe_out,
  output logic tsm_excite,
  output logic comp_out,
  output logic aclk,
  output logic sub_main_clock,
  output logic osc_clk,
  output logic seq_end
);
  int n = 0;
  int s = 0;
  assign afe_out = afe_set;
  assign {tsm_excite, comp_out} = ec_set;
  // Free-running clocks of 16, 6 and 4 cycles, oscillator edges offset from aux edges
  assign aclk = (n % 16) < 8;
  assign sub_main_clock = (n % 6) < 3;
  assign osc_clk = ((n + 1) % 4) < 2;
  // Each started sequence ends five cycles later
  assign seq_end = s == 5;
  always @(posedge clock) begin
    n <= n + 1;
    s <= seq_start ? 1 : (s != 0 && s < 5) ? s + 1 : 0;
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import scn_pkg::*;
();
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h3;
  logic entry_strobe = 1'b0;
  logic [7:0] entry_bits = 8'h00;
  logic [3:0] afe_set = 4'h0;
  logic [1:0] ec_set = 2'h0;
  logic [31:0] readdata, q;
  logic waitrequest, aclk, sub_main_clock, osc_clk, tsm_excite, comp_out, seq_end, seq_start;
  logic aclk_tick, sub_main_clock_tick, hf_clk_sel, osc_nominal_sel, out_cond_flag, cnt_a_flag, cnt_b_flag;
  logic [3:0] afe_out, osc_trim;
  scn_src_t psm_src;
  scn_next_t next_use;
  int mismatches = 0;
  int cmp_count = 0;

  scn_if dut (.clock, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .afe_out, .aclk, .sub_main_clock, .osc_clk, .tsm_excite, .comp_out,
    .seq_end, .entry_strobe, .entry_bits, .psm_src, .next_use, .seq_start, .aclk_tick,
    .sub_main_clock_tick, .hf_clk_sel, .osc_trim, .osc_nominal_sel, .out_cond_flag, .cnt_a_flag,
    .cnt_b_flag);
  scn_afe_model afe (.clock, .afe_set, .ec_set, .seq_start, .afe_out, .tsm_excite,
    .comp_out, .aclk, .sub_main_clock, .osc_clk, .seq_end);

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("mismatch at %0t: wait timed out", $time);
    final_report();
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
    int k = 0;
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) hang();
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask

  task automatic strobe(input logic [7:0] b, input int n);
    repeat (n) begin
      entry_strobe <= 1'b1;
      entry_bits <= b;
      @(posedge clock);
      entry_strobe <= 1'b0;
      @(posedge clock);
    end
  endtask

  // Cycles between the second and third pulse of seq_start or a tick output
  task automatic gap(input int sel, input int exp);
    int k = 0;
    int t0 = 0;
    int p = 0;
    logic v;
    while (p < 3 && k < 2000) begin
      @(posedge clock);
      k++;
      v = (sel == 0) ? seq_start : (sel == 1) ? aclk_tick : sub_main_clock_tick;
      if (v === 1'b1) begin
        p++;
        if (p == 2) t0 = k;
        if (p == 3) chk(k - t0, exp);
      end
    end
    if (p < 3) hang();
  endtask

  // Poll until calibration start bit drops, then compare the register
  task automatic cal(input logic [15:0] exp);
    int k = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && k < 100) begin
      bus(1'b0, ADDR_OSC, 16'h0000);
      k++;
    end
    if (k >= 100) hang();
    chk(q, {16'h0000, exp});
  endtask

  initial begin
    logic [3:0] pat;
    pat = 4'ha;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk(osc_trim, 32'h8);
    rd(ADDR_SRC, 16'h0000);
    rd(ADDR_CTL, 16'h0000);
    rd(ADDR_OSC, 16'h0040);
    wr(5'h14, 16'hffff);
    rd(5'h14, 16'h0000);
    afe_set <= pat;
    ec_set <= 2'h2;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SRC, 16'h0080 | (c << 14) | ((3 - c) << 12));
      repeat (3) @(posedge clock);
      chk(psm_src, {30'h0, pat[c], pat[3 - c]});
    end
    rd(ADDR_SRC, 16'hc08a);
    wr(ADDR_SRC, 16'h0000);
    repeat (3) @(posedge clock);
    chk(psm_src, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL, k << 10);
      strobe(8'hc0, 1);
      chk(next_use, {30'h0, k == 3, k[0]});
    end
    wr(ADDR_FLG, 16'h0007);
    wr(ADDR_CTL, 16'h1000);
    strobe(8'h02, 3);
    rd(ADDR_CNT, 16'h0003);
    chk(cnt_a_flag, 32'h1);
    wr(ADDR_CTL, 16'h0000);
    strobe(8'h06, 2);
    rd(ADDR_CNT, 16'h0003);
    wr(ADDR_CTL, 16'h6000);
    strobe(8'h04, 4);
    rd(ADDR_CNT, 16'hfcff);
    chk(cnt_a_flag, 32'h1);
    wr(ADDR_FLG, 16'h0007);
    chk({cnt_b_flag, cnt_a_flag}, 32'h0);
    wr(ADDR_CTL, 16'he000);
    rd(ADDR_CNT, 16'hfcff);
    rd(ADDR_CNT, 16'h0000);
    wr(ADDR_SRC, 16'h0700);
    wr(ADDR_CTL, 16'h4000);
    wr(ADDR_FLG, 16'h0007);
    strobe(8'h04, 3);
    chk(cnt_b_flag, 32'h0);
    strobe(8'h04, 1);
    chk(cnt_b_flag, 32'h1);
    wr(ADDR_CTL, 16'h1000);
    strobe(8'h02, 255);
    chk(cnt_a_flag, 32'h0);
    strobe(8'h02, 1);
    chk(cnt_a_flag, 32'h1);
    wr(ADDR_SRC, 16'h0040);
    wr(ADDR_FLG, 16'h0007);
    repeat (6) @(posedge clock);
    chk(out_cond_flag, 32'h0);
    wr(ADDR_SRC, 16'h0050);
    repeat (6) @(posedge clock);
    chk(out_cond_flag, 32'h1);
    wr(ADDR_FLG, 16'h0007);
    repeat (6) @(posedge clock);
    chk(out_cond_flag, 32'h0);
    wr(ADDR_CTL, 16'h00a3);
    gap(0, 480);
    gap(2, 48);
    wr(ADDR_CTL, 16'h0008);
    gap(1, 64);
    // Enable repeat while a triggered sequence is in flight
    for (int k = 0; k < 100 && seq_start !== 1'b1; k++) @(posedge clock);
    if (seq_start !== 1'b1) hang();
    wr(ADDR_OSC, 16'h00c0);
    gap(0, 6);
    wr(ADDR_OSC, 16'h0043);
    cal(16'h0441);
    chk(hf_clk_sel, 32'h1);
    wr(ADDR_OSC, 16'h0047);
    cal(16'h1045);
    chk(osc_nominal_sel, 32'h1);
    wr(ADDR_OSC, 16'h0042);
    repeat (80) @(posedge clock);
    rd(ADDR_OSC, 16'h1042);
    chk(hf_clk_sel, 32'h0);
    wr(ADDR_OSC, 16'h0078);
    chk(osc_trim, 32'hf);
    final_report();
  end
endmodule
